// ### verilog/fps_top.sv
// Power-up and reset entry sequencer of a serial flash SPI slave.
// Assumes RST comes from the internal power-on detector, synchronous to
// MCLK, and that the SPI pins are asynchronous and synchronised here.
`timescale 1ns/1ps
module fps_top
#(
	parameter int unsigned PGM_DELAY_CYC = fps_pkg::PGM_DELAY_CYC
)
(
	// Clock and reset
	input wire logic MCLK,
	input wire logic RST,
	// SPI pins from the host
	input wire logic CHIP_SELECT_N,
	input wire logic SCK,
	// Serial data output from the command core
	input wire logic CORE_SO,
	input wire logic CORE_SO_DRIVE,
	// Serial data output pin, enable low while driving
	output logic SO_DATA,
	output logic SO_OE_N,
	// Status towards the command core
	output fps_pkg::fps_status_t STATUS,
	output logic FRAME_START
);

	logic cs_n_s;
	logic sck_s;
	logic cs_n_prev_q;
	logic cs_n_prev_d;
	logic cs_fall;
	logic cs_rise;
	logic [2:0] warm_q;
	logic [2:0] warm_d;
	fps_pkg::fps_state_t state_q;
	fps_pkg::fps_state_t state_d;
	logic [fps_pkg::CNT_W-1:0] cnt_q;
	logic [fps_pkg::CNT_W-1:0] cnt_d;
	logic delay_done_q;
	logic delay_done_d;
	logic mode_q;
	logic mode_d;
	logic armed_q;
	logic armed_d;
	logic so_q;
	logic so_d;
	logic oe_n_q;
	logic oe_n_d;
	fps_pkg::fps_status_t stat_q;
	fps_pkg::fps_status_t stat_d;
	logic start_q;
	logic start_d;

	// Chip select idles high so no false edge appears at reset release
	fps_sync #(.RST_VAL(1'b1)) u_cs_sync
	(
		.clk(MCLK),
		.rst(RST),
		.din(CHIP_SELECT_N),
		.dout(cs_n_s)
	);

	fps_sync #(.RST_VAL(1'b0)) u_sck_sync
	(
		.clk(MCLK),
		.rst(RST),
		.din(SCK),
		.dout(sck_s)
	);

	// Edge detect on the synchronised chip select, the fall alone gated until both sync
	// stages and the previous-level flop hold real pin samples; a select
	// held low through reset would otherwise look like a fresh fall
	assign cs_fall = cs_n_prev_q & ~cs_n_s & warm_q[2];
	assign cs_rise = ~cs_n_prev_q & cs_n_s;

	// Warm-up shift and previous select level
	always_comb
	begin
		warm_d = {warm_q[1:0], 1'b1};
		cs_n_prev_d = cs_n_s;
	end

	// Power-up delay counter; counts only out of reset
	always_comb
	begin
		cnt_d = cnt_q;
		delay_done_d = delay_done_q;
		if (!delay_done_q)
		begin
			if (cnt_q >= PGM_DELAY_CYC[fps_pkg::CNT_W-1:0] - 20'h00001)
				delay_done_d = 1'b1;
			else
				cnt_d = cnt_q + 20'h00001;
		end
	end

	// Sequencer and mode capture
	always_comb
	begin
		state_d = state_q;
		mode_d = mode_q;
		armed_d = armed_q;
		start_d = 1'b0;
		if (cs_fall)
		begin
			mode_d = sck_s ? fps_pkg::MODE_3 : fps_pkg::MODE_0;
			armed_d = 1'b1;
			start_d = 1'b1;
		end
		else if (cs_rise)
			armed_d = 1'b0;
		// Mode is only rewritten on a falling edge, so it holds all frame
		unique case (state_q)
			fps_pkg::ST_RESET:
				state_d = fps_pkg::ST_WAIT_EDGE;
			fps_pkg::ST_WAIT_EDGE:
			begin
				if (delay_done_q)
					state_d = cs_n_s ? fps_pkg::ST_STANDBY : fps_pkg::ST_ACTIVE;
			end
			fps_pkg::ST_STANDBY:
			begin
				if (!cs_n_s)
					state_d = fps_pkg::ST_ACTIVE;
			end
			fps_pkg::ST_ACTIVE:
			begin
				if (cs_n_s)
					state_d = fps_pkg::ST_STANDBY;
			end
		endcase
	end

	// Output pin and status; output floats until a frame is armed
	always_comb
	begin
		so_d = 1'b0;
		oe_n_d = 1'b1;
		if (armed_d && !cs_n_s && CORE_SO_DRIVE)
		begin
			so_d = CORE_SO;
			oe_n_d = 1'b0;
		end
		// Commands only once a falling edge armed the frame
		stat_d.ready = (state_q != fps_pkg::ST_RESET);
		stat_d.cmd_enable = armed_d && !cs_n_s;
		// Program and erase gated by the internal power-up delay counter
		stat_d.pgm_allowed = delay_done_q;
		stat_d.spi_mode = mode_d;
		stat_d.active = (state_d == fps_pkg::ST_ACTIVE);
	end

	// Edge detector registers; warm-up keeps stale sync values out
	always_ff @(posedge MCLK)
	begin
		if (RST)
		begin
			cs_n_prev_q <= 1'b1;
			warm_q <= 3'h0;
		end
		else
		begin
			cs_n_prev_q <= cs_n_prev_d;
			warm_q <= warm_d;
		end
	end

	// Power-up delay registers
	always_ff @(posedge MCLK)
	begin
		if (RST)
		begin
			cnt_q <= 20'h00000;
			delay_done_q <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_d;
			delay_done_q <= delay_done_d;
		end
	end

	// Sequencer registers; reset blocks every command
	always_ff @(posedge MCLK)
	begin
		if (RST)
		begin
			state_q <= fps_pkg::ST_RESET;
			mode_q <= fps_pkg::MODE_0;
			armed_q <= 1'b0;
			start_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			mode_q <= mode_d;
			armed_q <= armed_d;
			start_q <= start_d;
		end
	end

	// Output registers; the pin floats through reset
	always_ff @(posedge MCLK)
	begin
		if (RST)
		begin
			so_q <= 1'b0;
			oe_n_q <= 1'b1;
			stat_q <= '0;
		end
		else
		begin
			so_q <= so_d;
			oe_n_q <= oe_n_d;
			stat_q <= stat_d;
		end
	end

	assign SO_DATA = so_q;
	assign SO_OE_N = oe_n_q;
	assign STATUS = stat_q;
	assign FRAME_START = start_q;

endmodule

// ### common/fps_pkg.sv
// Package for the serial flash power-up and reset entry sequencer.
// Assumes a single 250 MHz system clock; no software registers.
package fps_pkg;

	// System clock period in picoseconds
	localparam int unsigned CLK_PERIOD_PS = 4000;

	// Power-up delay before program or erase is allowed, microseconds
	localparam int unsigned PGM_DELAY_US = 3000;
	localparam int unsigned PGM_DELAY_CYC =
		(PGM_DELAY_US * 1000000) / CLK_PERIOD_PS;

	// Least wait from threshold to chip select low for a read, microseconds
	localparam int unsigned READ_DELAY_US = 70;
	localparam int unsigned READ_DELAY_CYC =
		(READ_DELAY_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// Width of the power-up counter
	localparam int unsigned CNT_W = 20;

	// SPI clock polarity encodings
	localparam logic MODE_0 = 1'b0;
	localparam logic MODE_3 = 1'b1;

	// Sequencer states
	typedef enum logic [1:0]
	{
		ST_RESET = 2'b00,
		ST_WAIT_EDGE = 2'b01,
		ST_STANDBY = 2'b10,
		ST_ACTIVE = 2'b11
	} fps_state_t;

	// Status bundle reported to the command logic
	typedef struct packed
	{
		logic ready;
		logic cmd_enable;
		logic pgm_allowed;
		logic spi_mode;
		logic active;
	} fps_status_t;

endpackage

// ### verilog/fps_sync.sv
// Two-flop synchroniser for one pin level.
// Assumes the pin is asynchronous to MCLK.
`timescale 1ns/1ps
module fps_sync
#(
	parameter logic RST_VAL = 1'b0
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic din,
	output logic dout
);

	logic meta_q;
	logic meta_d;
	logic out_q;
	logic out_d;

	// Next values; first flop feeds only the second
	always_comb
	begin
		meta_d = din;
		out_d = meta_q;
	end

	// Register stage
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			meta_q <= RST_VAL;
			out_q <= RST_VAL;
		end
		else
		begin
			meta_q <= meta_d;
			out_q <= out_d;
		end
	end

	assign dout = out_q;

endmodule

// ### test/fps_top_asserts.sv
// Checker on fps_top ports.
// Assumes one clock domain; bound below.
`timescale 1ns/1ps
module fps_chk
(
	// Clock and reset
	input wire logic MCLK,
	input wire logic RST,
	// Watched pins
	input wire logic SCK,
	input wire logic SO_OE_N,
	input wire fps_pkg::fps_status_t STATUS,
	input wire logic FRAME_START
);
	default clocking @(posedge MCLK);
	endclocking
	default disable iff (RST);
	// Pin stays quiet until armed
	oe_idle_a: assert property (
		!STATUS.cmd_enable |-> SO_OE_N) else $error("drive unarmed");
	arm_start_a: assert property (
		$rose(STATUS.cmd_enable) |-> FRAME_START) else $error("no start");
	mode_pick_a: assert property (
		FRAME_START |-> STATUS.spi_mode == SCK) else $error("bad mode");
	reset_quiet_a: assert property (
		$fell(RST) |-> STATUS == 5'h0 && SO_OE_N) else $error("busy reset");
	active_late_a: assert property (
		STATUS.active |-> STATUS.pgm_allowed) else $error("early active");
	// Mode frozen while the frame runs
	mode_hold_a: assert property (
		STATUS.cmd_enable && $past(STATUS.cmd_enable) |->
		$stable(STATUS.spi_mode)) else $error("mode moved");
endmodule

bind fps_top fps_chk chk_u (.MCLK(MCLK), .RST(RST), .SCK(SCK),
	.SO_OE_N(SO_OE_N), .STATUS(STATUS), .FRAME_START(FRAME_START));

// ### test/fps_host.sv
// Host model: chip select and clock idle level.
// Assumes calls from the bench task by task.
`timescale 1ns/1ps
module fps_host
(
	// Clock
	input wire logic clk,
	// Pins
	output logic cs_n,
	output logic sck
);
	// Idle deselected
	initial
	begin
		cs_n = 1'b1;
		sck = 1'b0;
	end
	// Level of chip select
	task automatic set_cs(input logic v);
		@(posedge clk);
		cs_n <= v;
	endtask
	// Deselect, set clock level, then fall
	task automatic frame_open(input logic m);
		@(posedge clk);
		cs_n <= 1'b1;
		sck <= m;
		repeat (3) @(posedge clk);
		cs_n <= 1'b0;
	endtask
	// No command before the power-up delays
	task automatic power_wait(input int n);
		repeat (n) @(posedge clk);
	endtask
endmodule

// ### test/tb_top.sv
// Bench for the power-up sequencer.
// Assumes fps_host on the pins and the bound checker.
`timescale 1ns/1ps
module tb_top;
	localparam int unsigned DLY = 20;
	logic mclk, rst, so, drv, so_out, oe_n, fs, cs_n, sck;
	fps_pkg::fps_status_t st;
	int err_count, n_compared;
	// 250 MHz clock
	initial
	begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	fps_host host_u (.clk(mclk), .cs_n(cs_n), .sck(sck));
	fps_top #(.PGM_DELAY_CYC(DLY)) dut_u (.MCLK(mclk), .RST(rst),
		.CHIP_SELECT_N(cs_n), .SCK(sck), .CORE_SO(so),
		.CORE_SO_DRIVE(drv), .SO_DATA(so_out), .SO_OE_N(oe_n),
		.STATUS(st), .FRAME_START(fs));
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		n_compared++;
		if (g !== e)
		begin
			err_count++;
			$display("wrong value %0t %h %h", $time, g, e);
		end
	endtask
	task automatic print_verdict();
		$display("errors %0d compared %0d", err_count, n_compared);
		if (err_count == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Reset with a chosen select level, core asking to drive
	task automatic boot(input logic cs);
		@(posedge mclk);
		rst <= 1'b1;
		drv <= 1'b1;
		so <= 1'b1;
		host_u.set_cs(cs);
		repeat (5) @(negedge mclk);
		chk({2'h0, oe_n, st}, 8'h20);
		@(posedge mclk);
		rst <= 1'b0;
		host_u.power_wait(10);
		@(negedge mclk);
		chk({2'h0, oe_n, st}, 8'h30);
		host_u.power_wait(18);
		@(negedge mclk);
		chk({2'h0, oe_n, st}, {2'h0, 5'h1A, ~cs});
	endtask
	// One frame per clock level
	task automatic frame(input logic m);
		host_u.frame_open(m);
		for (int i = 0; i < 20 && fs !== 1'b1; i++)
			@(negedge mclk);
		if (fs !== 1'b1)
		begin
			err_count++;
			print_verdict();
		end
		chk({6'h00, st.cmd_enable, st.spi_mode}, {7'h01, m});
		@(negedge mclk);
		chk({7'h00, fs}, 8'h00);
		host_u.power_wait(6);
		@(negedge mclk);
		chk({5'h00, oe_n, so_out, st.spi_mode}, {7'h01, m});
		host_u.set_cs(1'b1);
		repeat (5) @(negedge mclk);
		chk({6'h00, oe_n, st.cmd_enable}, 8'h02);
	endtask
	// Main sequence
	initial
	begin
		rst = 1'b1;
		so = 1'b0;
		drv = 1'b0;
		err_count = 0;
		n_compared = 0;
		boot(1'b0);
		host_u.power_wait(int'(fps_pkg::READ_DELAY_CYC));
		frame(1'b1);
		frame(1'b0);
		boot(1'b1);
		print_verdict();
	end
endmodule
